// ### rtl/bct_pkg.sv
// bct_pkg: types of the broadcast conversion trigger
// assumes bct_regs.svh supplies the numbers
package bct_pkg;

   typedef enum logic [3:0] {
      BCT_IDLE  = 4'h0,
      BCT_ADDR  = 4'h1,
      BCT_AACK  = 4'h3,
      BCT_PTR   = 4'h2,
      BCT_PACK  = 4'h6,
      BCT_WHI   = 4'h7,
      BCT_WACKH = 4'h5,
      BCT_WLO   = 4'h4,
      BCT_WACKL = 4'hc,
      BCT_RD    = 4'hd,
      BCT_RACK  = 4'hf
   } bct_st_t;

   // command word layout, msb first
   typedef struct packed {
      logic       rsv;
      logic [1:0] bus_range_select;
      logic [1:0] shunt_gain_select;
      logic [3:0] bus_acq_time;
      logic [3:0] shunt_acq_time;
      logic [2:0] mode;
   } bct_cmd_t;

   typedef struct packed {
      logic       scl_s1;
      logic       scl_s2;
      logic       scl_d;
      logic       sda_s1;
      logic       sda_s2;
      logic       sda_d;
      logic [6:0] addr_s1;
      logic [6:0] own_addr;
      bct_st_t    st;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [7:0] ptr;
      logic [7:0] hi;
      logic       rnw;
      logic       byte_lo;
      logic       mack;
      logic       sda_drv;
      bct_cmd_t   cmd;
      logic [15:0] res;
      logic       busy;
      logic       phase;
      logic [19:0] tmr;
   } bct_state_t;

endpackage

// ### rtl/bct_regs.svh
// bct_regs.svh: offsets, field values, reset values and timing figures of the broadcast conversion trigger
// assumes a single 125 MHz clock and inclusion by bare name
`ifndef BCT_REGS_SVH
`define BCT_REGS_SVH

`define BCT_BCAST_ADDR   7'h7f
`define BCT_REG_CMD      8'h00
`define BCT_REG_RES3     8'h03
`define BCT_CMD_RST      16'h0000
`define BCT_MODE_BOTH    3'h3
`define BCT_ACQ_LONG     4'h3
`define BCT_RANGE_LOW    2'h0
`define BCT_CLK_NS       8
`define BCT_ACQ508_NS    508000
`define BCT_ACQ508_CYC   (`BCT_ACQ508_NS / `BCT_CLK_NS)
`define BCT_ACQ_OTHER    1024

`endif

// ### rtl/bct_trigger.sv
// bct_trigger: two-wire register slave of a power monitor with broadcast-triggered conversion
// assumes scl/sda and the address straps come from pins; adc codes come from same-clock front-end logic
`timescale 1ns/100ps
`include "bct_regs.svh"

//////////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// RL1 - a write to slave address 0x7F is accepted whatever the own address is
// RL2 - register 0 holds bus range, shunt gain, both acquisition settings and mode
// RL3 - zero in both range fields selects 16V bus and 40mV shunt full scale
// RL4 - acquisition code 3 gives that channel 508us
// RL5 - mode 3 converts shunt then bus once, then stays idle
// RL6 - conversion starts as soon as the command write is executed
// RL7 - master programs identical ranges and acquisition settings into every monitor
// RL8 - after both conversions the master reads register 3 of each monitor in turn
// RL9 - master waits at least both acquisition times before reading results
module bct_trigger
   import bct_pkg::*;
#(
   parameter int ACQ_LONG_CYC  = `BCT_ACQ508_CYC,
   parameter int ACQ_OTHER_CYC = `BCT_ACQ_OTHER
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic [6:0]  dev_addr,
   input  wire logic [15:0] shunt_code,
   input  wire logic [15:0] bus_code,
   output logic [1:0]       bus_range_select,
   output logic [1:0]       shunt_gain_select,
   output logic             bus_lowest_range,
   output logic             shunt_lowest_range,
   output logic             sample_shunt,
   output logic             sample_bus,
   output logic             conv_busy
);

   bct_state_t s;
   bct_state_t next_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic       addr_hit;
   logic       wexec;
   logic [15:0] rd_word;

   function automatic logic [19:0] acq_cycles(input logic [3:0] code);
      if (code == `BCT_ACQ_LONG) begin
         acq_cycles = 20'(ACQ_LONG_CYC);
      end else begin
         acq_cycles = 20'(ACQ_OTHER_CYC);
      end
   endfunction

   assign scl_rise = s.scl_s2 & ~s.scl_d;
   assign scl_fall = ~s.scl_s2 & s.scl_d;
   assign start_c  = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
   assign stop_c   = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
   // broadcast only for writes; a read at the shared address would collide on the wire
   assign addr_hit = (s.sh[7:1] == s.own_addr) || (s.sh[7:1] == `BCT_BCAST_ADDR && !s.sh[0]); // RL1
   assign wexec    = scl_fall && s.st == BCT_WLO && s.bits == 4'h8 && s.ptr == `BCT_REG_CMD;
   assign rd_word  = (s.ptr == `BCT_REG_CMD) ? s.cmd : (s.ptr == `BCT_REG_RES3) ? s.res : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s         = s;
      next_s.scl_s1  = scl_in;
      next_s.scl_s2  = s.scl_s1;
      next_s.scl_d   = s.scl_s2;
      next_s.sda_s1  = sda_in;
      next_s.sda_s2  = s.sda_s1;
      next_s.sda_d   = s.sda_s2;
      next_s.addr_s1 = dev_addr;
      next_s.own_addr = s.addr_s1;

      if (scl_rise) begin
         case (s.st)
            BCT_ADDR, BCT_PTR, BCT_WHI, BCT_WLO, BCT_RD: begin
               next_s.sh   = {s.sh[6:0], s.sda_s2};
               next_s.bits = s.bits + 4'h1;
            end
            BCT_RACK: begin
               next_s.mack = ~s.sda_s2;
            end
            default: begin
            end
         endcase
      end

      if (scl_fall) begin
         case (s.st)
            BCT_ADDR: begin
               if (s.bits == 4'h8) begin
                  next_s.st      = addr_hit ? BCT_AACK : BCT_IDLE;
                  next_s.sda_drv = addr_hit;
                  next_s.rnw     = s.sh[0];
               end
            end
            BCT_AACK: begin
               next_s.bits = 4'h0;
               if (s.rnw) begin
                  next_s.st      = BCT_RD;
                  next_s.sh      = rd_word[15:8];
                  next_s.sda_drv = ~rd_word[15];
                  next_s.byte_lo = 1'b1;
               end else begin
                  next_s.st      = BCT_PTR;
                  next_s.sda_drv = 1'b0;
               end
            end
            BCT_PTR: begin
               if (s.bits == 4'h8) begin
                  next_s.ptr     = s.sh;
                  next_s.st      = BCT_PACK;
                  next_s.sda_drv = 1'b1;
               end
            end
            BCT_PACK, BCT_WACKL: begin
               next_s.st      = BCT_WHI;
               next_s.bits    = 4'h0;
               next_s.sda_drv = 1'b0;
            end
            BCT_WHI: begin
               if (s.bits == 4'h8) begin
                  next_s.hi      = s.sh;
                  next_s.st      = BCT_WACKH;
                  next_s.sda_drv = 1'b1;
               end
            end
            BCT_WACKH: begin
               next_s.st      = BCT_WLO;
               next_s.bits    = 4'h0;
               next_s.sda_drv = 1'b0;
            end
            BCT_WLO: begin
               if (s.bits == 4'h8) begin
                  next_s.st      = BCT_WACKL;
                  next_s.sda_drv = 1'b1;
                  if (wexec) begin
                     next_s.cmd = {s.hi, s.sh}; // RL2
                  end
               end
            end
            BCT_RD: begin
               if (s.bits == 4'h8) begin
                  next_s.st      = BCT_RACK;
                  next_s.sda_drv = 1'b0;
               end else begin
                  next_s.sda_drv = ~s.sh[7];
               end
            end
            BCT_RACK: begin
               next_s.bits = 4'h0;
               if (s.mack) begin
                  next_s.st      = BCT_RD;
                  next_s.sh      = s.byte_lo ? rd_word[7:0] : rd_word[15:8];
                  next_s.sda_drv = s.byte_lo ? ~rd_word[7] : ~rd_word[15];
                  next_s.byte_lo = ~s.byte_lo;
               end else begin
                  next_s.st = BCT_IDLE;
               end
            end
            default: begin
            end
         endcase
      end

      if (start_c) begin
         next_s.st      = BCT_ADDR;
         next_s.bits    = 4'h0;
         next_s.sda_drv = 1'b0;
      end else if (stop_c) begin
         next_s.st      = BCT_IDLE;
         next_s.sda_drv = 1'b0;
      end

      // conversion sequencer; a fresh command restarts it, mode bit 2 repeats it
      if (wexec) begin
         next_s.busy  = (s.sh[1:0] != 2'h0); // RL6
         next_s.phase = ~s.sh[0];
         next_s.tmr   = s.sh[0] ? acq_cycles(s.sh[6:3]) : acq_cycles({s.hi[2:0], s.sh[7]}); // RL4
      end else if (s.busy) begin
         if (s.tmr != 20'h0) begin
            next_s.tmr = s.tmr - 20'h1;
         end else if (!s.phase && s.cmd.mode[1]) begin
            next_s.phase = 1'b1; // RL5
            next_s.tmr   = acq_cycles(s.cmd.bus_acq_time);
         end else begin
            if (s.phase) begin
               next_s.res = bus_code;
            end else begin
               next_s.res = shunt_code;
            end
            next_s.busy  = s.cmd.mode[2]; // RL5
            next_s.phase = ~s.cmd.mode[0];
            next_s.tmr   = s.cmd.mode[0] ? acq_cycles(s.cmd.shunt_acq_time) : acq_cycles(s.cmd.bus_acq_time);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // bus synchronisers start at the idle-high line level so leaving reset fakes no edge
         s <= '{cmd: `BCT_CMD_RST, st: BCT_IDLE,
                scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                default: '0};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   assign sda_out            = 1'b0;
   assign sda_oe_n           = ~s.sda_drv;
   assign bus_range_select   = s.cmd.bus_range_select;
   assign shunt_gain_select  = s.cmd.shunt_gain_select;
   assign bus_lowest_range   = (s.cmd.bus_range_select == `BCT_RANGE_LOW); // RL3
   assign shunt_lowest_range = (s.cmd.shunt_gain_select == `BCT_RANGE_LOW); // RL3
   assign sample_shunt       = s.busy & ~s.phase;
   assign sample_bus         = s.busy & s.phase;
   assign conv_busy          = s.busy;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence bcast_addr_s;
      scl_fall && s.st == BCT_ADDR && s.bits == 4'h8 && s.sh == {`BCT_BCAST_ADDR, 1'b0};
   endsequence

   sequence both_last_s;
      s.busy && s.phase && s.tmr == 20'h0 && s.cmd.mode == `BCT_MODE_BOTH && !wexec;
   endsequence

   bcast_accept_a: assert property ((bcast_addr_s and (!start_c && !stop_c))
                                    |=> s.st == BCT_AACK && !sda_oe_n) // RL1
      else $error("broadcast write address not acknowledged");
   ack_drive_a: assert property (s.st == BCT_AACK |-> !sda_oe_n) // RL1
      else $error("address ack not driven low");
   cmd_store_a: assert property (wexec && !start_c && !stop_c |=> s.cmd == {$past(s.hi), $past(s.sh)}) // RL2
      else $error("command register not loaded by write");
   low_range_a: assert property (s.cmd.bus_range_select == 2'h0 && s.cmd.shunt_gain_select == 2'h0
                                 |-> bus_lowest_range && shunt_lowest_range) // RL3
      else $error("lowest ranges not selected");
   acq_long_a: assert property (wexec && s.sh[0] && s.sh[6:3] == `BCT_ACQ_LONG |=> s.tmr == 20'(ACQ_LONG_CYC)) // RL4
      else $error("shunt acquisition time not 508us");
   conv_start_a: assert property (wexec && s.sh[1:0] != 2'h0 |=> conv_busy) // RL6
      else $error("conversion did not start after command write");
   single_idle_a: assert property (both_last_s |=> !conv_busy ##1 !conv_busy) // RL5
      else $error("single acquisition did not go idle");
   shunt_then_bus_a: assert property (s.busy && !s.phase && s.tmr == 20'h0 && s.cmd.mode == `BCT_MODE_BOTH && !wexec
                                      |=> sample_bus && s.tmr == acq_cycles(s.cmd.bus_acq_time)) // RL5
      else $error("bus channel did not follow shunt channel");

endmodule

// ### testbench/bct_master.sv
// bct_master: behavioural two-wire bus master that drives the monitor's bus pins
// assumes a pull-up on sda, so a released line reads high, and a clock well above the bus rate
`timescale 1ns/100ps

module bct_master #(
   parameter int HALF = 5
) (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic wt();
      repeat (HALF) @(posedge clk);
   endtask

   // raising sda before scl also makes this a repeated start when scl is low
   task automatic start();
      sda_drv <= 1'b1;
      wt();
      scl <= 1'b1;
      wt();
      sda_drv <= 1'b0;
      wt();
      scl <= 1'b0;
      wt();
   endtask

   task automatic stop();
      sda_drv <= 1'b0;
      wt();
      scl <= 1'b1;
      wt();
      sda_drv <= 1'b1;
      wt();
   endtask

   // data only moves while scl is low, a full half period away from either scl edge
   task automatic one_bit(input logic d, output logic q);
      sda_drv <= d;
      wt();
      scl <= 1'b1;
      wt();
      q = sda;
      scl <= 1'b0;
      wt();
   endtask

   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         one_bit(d[i], q[i]);
      end
      one_bit(mack, ack);
   endtask
endmodule

// ### testbench/bct_trigger_tb.sv
// bct_trigger_tb: self-checking bench for the broadcast conversion trigger
// assumes one monitor on the bus behind bct_master, with a pull-up on sda
`timescale 1ns/100ps
`include "bct_regs.svh"

module bct_trigger_tb;
   localparam int ACQ = 20;
   localparam int OTH = 10;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        scl;
   logic        m_sda;
   logic        sda_out;
   logic        sda_oe_n;
   logic [1:0]  bus_range_select;
   logic [1:0]  shunt_gain_select;
   logic        bus_lowest_range;
   logic        shunt_lowest_range;
   logic        sample_shunt;
   logic        sample_bus;
   logic        conv_busy;
   logic [15:0] sh_cnt = 16'h0000;
   logic [15:0] bu_cnt = 16'h0000;
   int          fail_count = 0;
   int          checks_done = 0;
   wire         sda = m_sda & (sda_oe_n | sda_out);

   bct_master m (.clk(clk), .sda(sda), .scl(scl), .sda_drv(m_sda));

   bct_trigger #(.ACQ_LONG_CYC(ACQ), .ACQ_OTHER_CYC(OTH)) bct_trigger_inst (
      .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .dev_addr(7'h45), .shunt_code(16'h1234), .bus_code(16'h5a3c), .bus_range_select(bus_range_select),
      .shunt_gain_select(shunt_gain_select), .bus_lowest_range(bus_lowest_range),
      .shunt_lowest_range(shunt_lowest_range), .sample_shunt(sample_shunt), .sample_bus(sample_bus),
      .conv_busy(conv_busy));

   always #4 clk = ~clk;

   // time spent acquiring, summed over the whole run
   always @(posedge clk) begin
      sh_cnt <= sh_cnt + {15'h0, sample_shunt};
      bu_cnt <= bu_cnt + {15'h0, sample_bus};
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input logic [3:0] ea);
      logic [3:0] k;
      logic [7:0] q;
      m.start();
      m.xfer({a, 1'b0}, 1'b1, q, k[3]);
      m.xfer(p, 1'b1, q, k[2]);
      m.xfer(d[15:8], 1'b1, q, k[1]);
      m.xfer(d[7:0], 1'b1, q, k[0]);
      m.stop();
      chk("write acks", {12'h0, k}, {12'h0, ea});
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] p, input logic ea, input logic [15:0] e);
      logic       k;
      logic [7:0] h;
      logic [7:0] l;
      m.start();
      m.xfer({a, 1'b0}, 1'b1, h, k);
      m.xfer(p, 1'b1, h, k);
      m.start();
      m.xfer({a, 1'b1}, 1'b1, h, k);
      chk("read ack", {15'h0, k}, {15'h0, ea});
      if (k === 1'b0) begin
         m.xfer(8'hff, 1'b0, h, k);
         m.xfer(8'hff, 1'b1, l, k);
         chk("read data", {h, l}, e);
      end
      m.stop();
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("reset flags", {12'h0, bus_lowest_range, shunt_lowest_range, conv_busy, sda_oe_n}, 16'h000d);
      wr(`BCT_BCAST_ADDR, `BCT_REG_CMD, 16'h019b, 4'h0);
      chk("conv started", {15'h0, conv_busy}, 16'h0001);
      chk("lowest ranges", {12'h0, bus_range_select, shunt_gain_select}, 16'h0000);
      chk("lowest flags", {14'h0, bus_lowest_range, shunt_lowest_range}, 16'h0003);
      for (int i = 0; i < 300 && conv_busy !== 1'b0; i++) @(posedge clk);
      chk("shunt acq time", sh_cnt, 16'(ACQ + 1));
      chk("bus acq time", bu_cnt, 16'(ACQ + 1));
      repeat (50) @(posedge clk);
      chk("stays idle", {14'h0, conv_busy, sample_bus}, 16'h0000);
      rd(7'h45, `BCT_REG_RES3, 1'b0, 16'h5a3c);
      rd(7'h45, `BCT_REG_CMD, 1'b0, 16'h019b);
      $display("test 1 done");
      rd(`BCT_BCAST_ADDR, `BCT_REG_CMD, 1'b1, 16'h0000);
      wr(7'h22, `BCT_REG_CMD, 16'h7800, 4'hf);
      rd(7'h45, `BCT_REG_CMD, 1'b0, 16'h019b);
      $display("test 2 done");
      wr(7'h45, `BCT_REG_CMD, 16'h7800, 4'h0);
      chk("range fields", {10'h0, bus_range_select, shunt_gain_select, bus_lowest_range, shunt_lowest_range},
          16'h003c);
      chk("mode zero idle", {15'h0, conv_busy}, 16'h0000);
      $display("test 3 done");
      // shunt-only single shot with a short acquisition code: register 3 then holds the shunt code
      wr(7'h45, `BCT_REG_CMD, 16'h0001, 4'h0);
      repeat (20) @(posedge clk);
      chk("shunt only done", {15'h0, conv_busy}, 16'h0000);
      chk("shunt only time", sh_cnt, 16'(ACQ + 1 + OTH + 1));
      chk("shunt only bus", bu_cnt, 16'(ACQ + 1));
      rd(7'h45, `BCT_REG_RES3, 1'b0, 16'h1234);
      $display("test 4 done");
      // continuous shunt mode keeps converting until a new command stops it
      wr(7'h45, `BCT_REG_CMD, 16'h0005, 4'h0);
      repeat (100) @(posedge clk);
      chk("continuous busy", {14'h0, conv_busy, sample_shunt}, 16'h0003);
      wr(7'h45, `BCT_REG_CMD, 16'h0000, 4'h0);
      chk("continuous stop", {15'h0, conv_busy}, 16'h0000);
      $display("test 5 done");
      print_verdict();
   end
endmodule
